// ===== verilog/pwm_ten_bit.sv
// Purpose : ten-bit pwm generator of the second timer, apb register slave
// Assumes : apb master keeps the protocol; inputs synchronous to clk
// Notes   : one-cycle access phase, unmapped addresses answer pslverr
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module pwm_ten_bit
    import pwm_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // shared pwm output pin
    output logic                   pwm_pin_out,
    output logic                   pwm_pin_oe
);
    typedef struct packed {
        logic [7:0]       period_low;
        logic [7:0]       duty_low;
        logic [7:0]       upper_bits;
        logic [7:0]       timer_mode;
        logic [7:0]       port_mode;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] duty_act;
        run_state_t       st;
        logic             pin;
        logic             oe;
        logic             ready;
        logic             slverr;
        logic [31:0]      rdata;
    } pwm_state_t;

    pwm_state_t s_q;
    pwm_state_t s_d;

    pwm_tick_if tk ();

    // joins two upper bits and a low byte into a ten-bit value
    function automatic logic [CNT_W-1:0] join10(input logic [1:0] hi, input logic [7:0] lo);
        join10 = {hi, lo};
    endfunction : join10

    logic [CNT_W-1:0] period_val;
    logic [CNT_W-1:0] duty_hold;
    logic             pwm_mode;
    logic             run_bit;
    logic             pol;
    logic             setup;
    logic             wr_en;
    logic             mapped;
    logic             active;

    // decoded fields of the programmed registers
    assign period_val = join10(s_q.upper_bits[UP_PERIOD_LSB +: 2], s_q.period_low);
    assign duty_hold  = join10(s_q.upper_bits[UP_DUTY_LSB +: 2], s_q.duty_low);
    assign pwm_mode   = s_q.port_mode[PORT_PWM_BIT] & s_q.timer_mode[MODE_PWM_ENABLE_BIT_BIT];
    assign run_bit    = s_q.timer_mode[MODE_RUN_BIT];
    assign pol        = s_q.timer_mode[MODE_POL_BIT];
    assign setup      = psel & ~penable;
    assign wr_en      = psel & penable & s_q.ready & pwrite & ~s_q.slverr;
    assign mapped     = (paddr == OFF_PERIOD_LOW) || (paddr == OFF_DUTY_LOW) ||
                        (paddr == OFF_UPPER_BITS) || (paddr == OFF_TIMER_MODE) ||
                        (paddr == OFF_PORT_MODE)  || (paddr == OFF_STATUS);

    // prescaler only ticks while the pwm is enabled and started
    assign tk.sel = s_q.timer_mode[MODE_CLK_LSB +: 2];
    assign tk.run = pwm_mode & run_bit;

    pwm_prescaler u_pre (
        .clk    (clk),
        .resetn (resetn),
        .tk     (tk)
    );

    // next-state logic for bus, counter and pin
    always_comb begin
        s_d        = s_q;
        s_d.ready  = 1'b0;
        s_d.slverr = 1'b0;
        active     = 1'b0;

        // apb: answer in the first access cycle, read data registered at setup
        if (setup) begin
            s_d.ready  = 1'b1;
            s_d.slverr = ~mapped;
            s_d.rdata  = 32'h0000_0000;
            case (paddr)
                OFF_PERIOD_LOW: s_d.rdata[7:0] = s_q.period_low;
                OFF_DUTY_LOW:   s_d.rdata[7:0] = s_q.duty_low;
                OFF_UPPER_BITS: s_d.rdata[7:0] = s_q.upper_bits;
                OFF_TIMER_MODE: s_d.rdata[7:0] = s_q.timer_mode;
                OFF_PORT_MODE:  s_d.rdata[7:0] = s_q.port_mode;
                OFF_STATUS: begin
                    s_d.rdata[ST_CNT_LSB +: CNT_W] = s_q.cnt;
                    s_d.rdata[ST_PIN_BIT]          = s_q.pin;
                    s_d.rdata[ST_RUN_BIT]          = (s_q.st == ST_RUN);
                end
                default:        s_d.rdata = 32'h0000_0000;
            endcase
        end

        // register writes land on the sampling edge of the access phase
        if (wr_en) begin
            case (paddr)
                OFF_PERIOD_LOW: s_d.period_low = pwdata[7:0];
                OFF_DUTY_LOW:   s_d.duty_low   = pwdata[7:0]; // holding side only
                OFF_UPPER_BITS: s_d.upper_bits = {4'h0, pwdata[3:0]};
                OFF_TIMER_MODE: s_d.timer_mode = pwdata[7:0];
                OFF_PORT_MODE:  s_d.port_mode  = {7'h00, pwdata[0]};
                default:        s_d.port_mode  = s_q.port_mode;
            endcase
        end

        // counter: stopped state tracks holding duty so the first cycle is clean
        case (s_q.st)
            ST_STOP: begin
                s_d.cnt      = RST_CNT;
                s_d.duty_act = duty_hold;
                if (tk.run) begin
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!tk.run) begin
                    s_d.st = ST_STOP;
                    s_d.cnt = RST_CNT;
                end else if (tk.tick) begin
                    // live period compare: a short period ends the cycle sooner
                    if (s_q.cnt >= period_val) begin
                        s_d.cnt      = RST_CNT;
                        s_d.duty_act = duty_hold;
                    end else begin
                        s_d.cnt = s_q.cnt + CNT_W'(1);
                    end
                end
            end
            default: begin
                s_d.st = ST_STOP;
            end
        endcase

        // duty window: count zero to duty inclusive, zero duty never active
        // computed here from the next count, so the pin flop needs no extra stage
        if (s_d.duty_act == RST_CNT) begin
            active = 1'b0;
        end else begin
            active = (s_d.cnt <= s_d.duty_act);
        end

        // pin: pwm waveform while enabled, otherwise released
        if (pwm_mode) begin
            s_d.oe = 1'b1;
            if (s_d.st == ST_RUN) begin
                s_d.pin = active ? pol : ~pol;
            end else begin
                s_d.pin = ~pol;                              // idle at inactive level
            end
        end else begin
            s_d.oe  = 1'b0;
            s_d.pin = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q    <= '0;
            s_q.st <= ST_STOP;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign prdata      = s_q.rdata;
    assign pready      = s_q.ready;
    assign pslverr     = s_q.slverr;
    assign pwm_pin_out = s_q.pin;
    assign pwm_pin_oe  = s_q.oe;
endmodule : pwm_ten_bit

// ===== verilog/pwm_pkg.sv
// Purpose : shared constants and types for the ten-bit pwm block
// Assumes : apb with 32-bit data, 250 MHz system clock
// Notes   : register offsets are byte addresses, one word each
package pwm_pkg;
    // bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          CNT_W           = 10;
    // register byte offsets
    localparam logic [7:0]  OFF_PERIOD_LOW  = 8'h00;
    localparam logic [7:0]  OFF_DUTY_LOW    = 8'h04;
    localparam logic [7:0]  OFF_UPPER_BITS  = 8'h08;
    localparam logic [7:0]  OFF_TIMER_MODE  = 8'h0C;
    localparam logic [7:0]  OFF_PORT_MODE   = 8'h10;
    localparam logic [7:0]  OFF_STATUS      = 8'h14;
    // second_timer_mode_register fields
    localparam int          MODE_RUN_BIT    = 0;
    localparam int          MODE_CLK_LSB    = 1;
    localparam int          MODE_POL_BIT    = 3;
    localparam int          MODE_PWM_ENABLE_BIT_BIT   = 5;
    // port_mode_register field
    localparam int          PORT_PWM_BIT    = 0;
    // pwm_upper_bits fields
    localparam int          UP_PERIOD_LSB   = 2;
    localparam int          UP_DUTY_LSB     = 0;
    // status fields
    localparam int          ST_CNT_LSB      = 0;
    localparam int          ST_PIN_BIT      = 16;
    localparam int          ST_RUN_BIT      = 17;
    // reset values
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [9:0]  RST_CNT         = 10'h000;
    // clock select codes
    localparam logic [1:0]  CLK_SEL_250NS   = 2'h0;
    localparam logic [1:0]  CLK_SEL_500NS   = 2'h1;
    localparam logic [1:0]  CLK_SEL_2US     = 2'h2;
    // timing: source clock periods in ns, system period in ps
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          SRC0_NS         = 250;
    localparam int          SRC1_NS         = 500;
    localparam int          SRC2_NS         = 2000;
    localparam int          SRC0_CYC        = (SRC0_NS * 1000) / CLK_PERIOD_PS;
    localparam int          SRC1_CYC        = (SRC1_NS * 1000) / CLK_PERIOD_PS;
    localparam int          SRC2_CYC        = (SRC2_NS * 1000) / CLK_PERIOD_PS;
    localparam int          PRE_W           = 9;

    // counter states
    typedef enum logic [1:0] {
        ST_STOP = 2'b01,
        ST_RUN  = 2'b10
    } run_state_t;
endpackage : pwm_pkg

// ===== verilog/pwm_tick_if.sv
// Purpose : carries clock select and source tick between control and prescaler
// Assumes : single clock domain
// Notes   : tick is a one-cycle pulse
`timescale 1ns/1ps
interface pwm_tick_if;
    logic [1:0] sel;
    logic       run;
    logic       tick;
    modport ctl (output sel, output run, input tick);
    modport pre (input sel, input run, output tick);
endinterface : pwm_tick_if

// ===== verilog/pwm_prescaler.sv
// Purpose : derives the pwm source clock tick from the system clock
// Assumes : clk at 250 MHz
// Notes   : code 11 gives no tick, which holds the counter still
`timescale 1ns/1ps
module pwm_prescaler
    import pwm_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // control side
    pwm_tick_if.pre   tk
);
    typedef struct packed {
        logic [PRE_W-1:0] div;
        logic             tick;
    } pre_state_t;

    pre_state_t s_q;
    pre_state_t s_d;
    logic [PRE_W-1:0] limit;

    // divide ratio per select code, minus one for the terminal count
    always_comb begin
        case (tk.sel)
            CLK_SEL_250NS: limit = PRE_W'(SRC0_CYC - 1);
            CLK_SEL_500NS: limit = PRE_W'(SRC1_CYC - 1);
            CLK_SEL_2US:   limit = PRE_W'(SRC2_CYC - 1);
            default:       limit = '1;
        endcase
    end

    // free divider, restarted whenever the timer is stopped
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!tk.run || tk.sel == 2'h3) begin
            s_d.div = '0;
        end else if (s_q.div >= limit) begin
            s_d.div  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + PRE_W'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tk.tick = s_q.tick;
endmodule : pwm_prescaler

// ===== tb/pwm_ten_bit_chk.sv
// Purpose: bus and pin checks on the ten-bit pwm block
// Assumes: top ports only, one clock domain
// Notes  : bound from the bench top
`timescale 1ns/1ps
module pwm_ten_bit_chk
    import pwm_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // pin
    input wire logic              pwm_pin_out,
    input wire logic              pwm_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // zero wait states: one answer per setup, only in the access cycle
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_unmapped: assert property (psel && !penable && paddr > OFF_STATUS |=> pslverr)
        else $error("no error on unmapped");
    a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("data on error");
    a_rdata_narrow: assert property (pready && !pwrite && paddr != OFF_STATUS
        |-> prdata[31:8] == 24'h0) else $error("wide read data");
    // pin select cleared must release the pin within three cycles
    a_oe_follows_select: assert property (pready && pwrite && paddr == OFF_PORT_MODE
        && !pwdata[PORT_PWM_BIT] |-> ##[1:3] !pwm_pin_oe) else $error("oe stays on");
    a_pin_idle_low: assert property (!pwm_pin_oe && $past(!pwm_pin_oe) |-> !pwm_pin_out)
        else $error("pin driven while off");
    c_refused: cover property (pready && pslverr);
    c_read: cover property (pready && !pwrite);
    c_pin_rise: cover property ($rose(pwm_pin_out));
endmodule : pwm_ten_bit_chk

// ===== tb/test_pwm_ten_bit.sv
// Purpose: self-checking bench for the ten-bit pwm block
// Assumes: zero wait state apb slave, registered pin
// Notes  : a monitor measures pin runs in clock cycles
`timescale 1ns/1ps
module test_pwm_ten_bit
    import pwm_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
    } row_t;
    logic              clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pwm_pin_out, pwm_pin_oe, er;
    logic              lvl = 1'h0;
    int                bad_count, n_tests, run_len, hi_len, lo_len, n_edges, e0;
    int                cyc [3];
    row_t              rows [7];

    pwm_ten_bit u_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pwm_pin_out, .pwm_pin_oe);

    // free running system clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // pulse monitor: length of the last finished high and low run
    always @(posedge clk) begin
        if (pwm_pin_out === lvl) begin
            run_len++;
        end else begin
            if (lvl) hi_len = run_len;
            else lo_len = run_len;
            lvl = pwm_pin_out;
            run_len = 1;
            n_edges++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // one apb transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'h1 && i < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (i >= 16) begin
            bad_count++;
            finish_test();
        end
    endtask : apb

    // waits for n pin edges, then for one landing on level l
    task automatic wait_edges(input int n, input logic l);
        int i;
        int s;
        i = 0;
        s = n_edges;
        while ((n_edges - s < n || lvl !== l) && i < 40000) begin
            @(negedge clk);
            i++;
        end
        if (i >= 40000) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_edges

    task automatic pulse(input int hi, input int lo, input int c);
        chk("high run", 32'(hi * c), 32'(hi_len));
        chk("low run", 32'(lo * c), 32'(lo_len));
    endtask : pulse

    // pin must hold level l for more than a whole period
    task automatic steady(input logic l);
        int s;
        wait_edges(1, l);
        s = n_edges;
        repeat (12 * SRC0_CYC) @(negedge clk);
        chk("edges", 32'h0, 32'(n_edges - s));
        chk("level", {31'h0, l}, {31'h0, pwm_pin_out});
    endtask : steady

    // stop first, then load; callers keep period nonzero and not below duty
    task automatic cfg(input logic [7:0] tm, input logic [9:0] per, input logic [9:0] dty);
        apb(1'h1, OFF_TIMER_MODE, {24'h0, tm & 8'hFE});
        apb(1'h1, OFF_PERIOD_LOW, {24'h0, per[7:0]});
        apb(1'h1, OFF_DUTY_LOW, {24'h0, dty[7:0]});
        apb(1'h1, OFF_UPPER_BITS, {28'h0, per[9:8], dty[9:8]});
        apb(1'h1, OFF_TIMER_MODE, {24'h0, tm});
    endtask : cfg

    // main sequence: registers first, then the waveform cases
    initial begin
        {resetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc = '{SRC0_CYC, SRC1_CYC, SRC2_CYC};
        rows = '{'{OFF_PERIOD_LOW, 32'h1A5, 32'hA5, 1'h0}, '{OFF_DUTY_LOW, 32'h5A, 32'h5A, 1'h0},
            '{OFF_UPPER_BITS, 32'hFF, 32'h0F, 1'h0}, '{OFF_PORT_MODE, 32'hFE, 32'h0, 1'h0},
            '{OFF_TIMER_MODE, 32'h2E, 32'h2E, 1'h0}, '{OFF_STATUS, 32'hFFFF, 32'h0, 1'h0},
            '{8'h40, 32'hFF, 32'h0, 1'h1}};
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        foreach (rows[k]) begin
            apb(1'h0, rows[k].a, 32'h0);
            chk("reset value", 32'h0, rd);
            apb(1'h1, rows[k].a, rows[k].w);
            apb(1'h0, rows[k].a, 32'h0);
            chk("read back", rows[k].r, rd);
            chk("error", {31'h0, rows[k].e}, {31'h0, er});
        end
        apb(1'h1, OFF_PORT_MODE, 32'h1);
        // duty 1 of period 5: two ticks on, four off, at every source clock
        for (int s = 0; s < 3; s++) begin
            cfg({4'h2, 1'h1, s[1:0], 1'h1}, 10'h005, 10'h001);
            wait_edges(4, 1'h1);
            chk("oe", 32'h1, {31'h0, pwm_pin_oe});
            pulse(2, 4, cyc[s]);
        end
        cfg(8'h21, 10'h005, 10'h001);
        wait_edges(4, 1'h1);
        pulse(4, 2, SRC0_CYC);
        cfg(8'h29, 10'h005, 10'h001);
        wait_edges(4, 1'h1);
        // duty written mid-pulse only counts from the next period
        apb(1'h1, OFF_DUTY_LOW, 32'h3);
        wait_edges(1, 1'h0);
        chk("old duty", 32'(2 * SRC0_CYC), 32'(hi_len));
        wait_edges(3, 1'h1);
        pulse(4, 2, SRC0_CYC);
        apb(1'h1, OFF_PERIOD_LOW, 32'h9);
        wait_edges(3, 1'h1);
        pulse(4, 6, SRC0_CYC);
        apb(1'h1, OFF_DUTY_LOW, 32'h9);
        steady(1'h1);
        apb(1'h1, OFF_DUTY_LOW, 32'h0);
        steady(1'h0);
        cfg(8'h29, 10'h101, 10'h100);
        wait_edges(4, 1'h1);
        pulse(257, 1, SRC0_CYC);
        // clock select 11 gives no ticks: count and pin freeze early in the high run
        apb(1'h1, OFF_TIMER_MODE, 32'h2F);
        e0 = n_edges;
        repeat (12 * SRC0_CYC) @(negedge clk);
        chk("frozen edges", 32'h0, 32'(n_edges - e0));
        apb(1'h0, OFF_STATUS, 32'h0);
        chk("frozen status", (32'h1 << ST_PIN_BIT) | (32'h1 << ST_RUN_BIT), rd);
        apb(1'h1, OFF_PORT_MODE, 32'h0);
        repeat (4) @(posedge clk);
        chk("oe off", 32'h0, {31'h0, pwm_pin_oe});
        // mid-run reset: pin driven high beforehand, all cleared at once
        apb(1'h1, OFF_PORT_MODE, 32'h1);
        repeat (2) @(posedge clk);
        resetn <= 1'h0;
        @(negedge clk);
        chk("reset oe", 32'h0, {31'h0, pwm_pin_oe});
        chk("reset pin", 32'h0, {31'h0, pwm_pin_out});
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        apb(1'h0, OFF_TIMER_MODE, 32'h0);
        chk("reset mode", 32'h0, rd);
        finish_test();
    end
endmodule : test_pwm_ten_bit

bind pwm_ten_bit pwm_ten_bit_chk u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwm_pin_out, .pwm_pin_oe);
